// ### hw/gate_drive_cfg_params.svh
`ifndef GATE_DRIVE_CFG_PARAMS_SVH
`define GATE_DRIVE_CFG_PARAMS_SVH
`define OFS_CHARGE 5'h0b
`define OFS_DISCHARGE 5'h0c
`define OFS_LIMIT 5'h0d
`define RST_ACT_CHARGE 16'h18c6
`define RST_FW_DRIVE 16'h18c6
`define RST_ACT_DISCHARGE 16'h1ce7
`define RST_PREDRAIN 16'h318c
`define RST_LIMIT_TIMING 16'h4900
`define MASK_CHARGE 16'h7fff
`define MASK_DISCHARGE 16'hffff
`define MASK_LIMIT 16'h7fff
`define SENSE_LOAD_BIT 15
`define CODE_W 5
`define LIMIT_W 2
`define TIME_W 3
`define BLANK4_LSB 12
`define CCP4_LSB 9
`define BLANK3_LSB 6
`endif

// ### hw/gate_drive_cfg_pkg.sv
package gate_drive_cfg_pkg;
    typedef logic [15:0] cfg_word_t;
    typedef logic [4:0] cfg_code_t;
    typedef logic [1:0] limit_code_t;
    typedef logic [2:0] time_code_t;
    // Drive phase of one channel, used to pick which code drives the gate
    typedef enum logic [2:0] {
        PH_IDLE = 3'h0,
        PH_PRECHARGE = 3'h1,
        PH_CHARGE = 3'h2,
        PH_POSTCHARGE = 3'h3,
        PH_PREDISCHARGE = 3'h4,
        PH_DISCHARGE = 3'h5
    } phase_t;
endpackage

// ### hw/cfg_word_reg.sv
`timescale 1ns/10ps
// One 16-bit register; bits outside the write mask hold zero forever
module cfg_word_reg #(
    parameter logic [15:0] RESET_VALUE = 16'h0000,
    parameter logic [15:0] WRITE_MASK = 16'hffff
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [15:0] wr_data,
    output logic [15:0] value
);
    logic [15:0] value_reg;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            value_reg <= RESET_VALUE & WRITE_MASK;
        end else if (wr_en) begin
            value_reg <= wr_data & WRITE_MASK;
        end
    end
    assign value = value_reg;
endmodule

// ### hw/channel_drive_select.sv
`timescale 1ns/10ps
// Picks the current code for one channel from its phase and side
module channel_drive_select (
    input wire logic freewheel_side,
    input wire gate_drive_cfg_pkg::phase_t phase,
    input wire logic [4:0] turnon_code,
    input wire logic [4:0] turnoff_code,
    input wire logic [4:0] freewheel_code,
    input wire logic [4:0] predrain_code,
    output logic [4:0] drive_code,
    output logic use_limit
);
    always_comb begin
        drive_code = 5'h00;
        use_limit = 1'b0;
        case (phase)
            gate_drive_cfg_pkg::PH_PRECHARGE,
            gate_drive_cfg_pkg::PH_POSTCHARGE: begin
                use_limit = 1'b1;
            end
            gate_drive_cfg_pkg::PH_PREDISCHARGE: begin
                use_limit = 1'b1;
                drive_code = predrain_code;
            end
            gate_drive_cfg_pkg::PH_CHARGE: begin
                drive_code = freewheel_side ? freewheel_code : turnon_code;
            end
            gate_drive_cfg_pkg::PH_DISCHARGE: begin
                drive_code = freewheel_side ? freewheel_code : turnoff_code;
            end
            default: begin
                drive_code = 5'h00;
            end
        endcase
    end
endmodule

// ### hw/gate_drive_current_cfg_bank.sv
`timescale 1ns/10ps
`include "gate_drive_cfg_params.svh"
module gate_drive_current_cfg_bank (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register access from the serial front end
    input wire logic bank_sel,
    input wire logic [4:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    output logic reg_hit,
    // Per-channel side in bit n and drive phase, channel n in bits 3n+2:3n
    input wire logic [2:0] freewheel_side,
    input wire logic [8:0] phase_bus,
    // Drive controls to the analog gate drivers
    output logic [14:0] drive_code_bus,
    output logic [2:0] limit_active,
    output logic [5:0] predrive_limit_bus,
    output logic [2:0] active_blanking_time_3,
    output logic [2:0] active_blanking_time_4,
    output logic [2:0] active_cross_conduction_time_4,
    output logic sense_load_large
);
    logic [15:0] act_charge;
    logic [15:0] fw_drive;
    logic [15:0] act_discharge;
    logic [15:0] predrain;
    logic [15:0] limit_timing;
    logic wr_act_charge;
    logic wr_fw_drive;
    logic wr_act_discharge;
    logic wr_predrain;
    logic wr_limit;
    logic hit;
    logic [15:0] rd_mux;
    logic [14:0] code_next;
    logic [2:0] use_limit_next;

    // Bank select steers each write at 0x0b or 0x0c to exactly one of the aliased pair
    always_comb begin
        wr_act_charge = 1'b0;
        wr_fw_drive = 1'b0;
        wr_act_discharge = 1'b0;
        wr_predrain = 1'b0;
        wr_limit = 1'b0;
        if (reg_addr == `OFS_CHARGE) begin
            wr_act_charge = reg_wr && !bank_sel;
            wr_fw_drive = reg_wr && bank_sel;
        end else if (reg_addr == `OFS_DISCHARGE) begin
            wr_act_discharge = reg_wr && !bank_sel;
            wr_predrain = reg_wr && bank_sel;
        end else if (reg_addr == `OFS_LIMIT) begin
            // The bank-1 twin at this offset lives in another block
            wr_limit = reg_wr && !bank_sel;
        end
    end

    cfg_word_reg #(
        .RESET_VALUE(`RST_ACT_CHARGE),
        .WRITE_MASK(`MASK_CHARGE)
    ) u_act_charge (
        .clk(clk),
        .rst_n(rst_n),
        .wr_en(wr_act_charge),
        .wr_data(reg_wdata),
        .value(act_charge)
    );

    cfg_word_reg #(
        .RESET_VALUE(`RST_FW_DRIVE),
        .WRITE_MASK(`MASK_CHARGE)
    ) u_fw_drive (
        .clk(clk),
        .rst_n(rst_n),
        .wr_en(wr_fw_drive),
        .wr_data(reg_wdata),
        .value(fw_drive)
    );

    cfg_word_reg #(
        .RESET_VALUE(`RST_ACT_DISCHARGE),
        .WRITE_MASK(`MASK_DISCHARGE)
    ) u_act_dis (
        .clk(clk),
        .rst_n(rst_n),
        .wr_en(wr_act_discharge),
        .wr_data(reg_wdata),
        .value(act_discharge)
    );

    cfg_word_reg #(
        .RESET_VALUE(`RST_PREDRAIN),
        .WRITE_MASK(`MASK_DISCHARGE)
    ) u_predrain (
        .clk(clk),
        .rst_n(rst_n),
        .wr_en(wr_predrain),
        .wr_data(reg_wdata),
        .value(predrain)
    );

    cfg_word_reg #(
        .RESET_VALUE(`RST_LIMIT_TIMING),
        .WRITE_MASK(`MASK_LIMIT)
    ) u_limit (
        .clk(clk),
        .rst_n(rst_n),
        .wr_en(wr_limit),
        .wr_data(reg_wdata),
        .value(limit_timing)
    );

    always_comb begin
        hit = 1'b1;
        rd_mux = 16'h0000;
        if (reg_addr == `OFS_CHARGE) begin
            rd_mux = bank_sel ? fw_drive : act_charge;
        end else if (reg_addr == `OFS_DISCHARGE) begin
            rd_mux = bank_sel ? predrain : act_discharge;
        end else if (reg_addr == `OFS_LIMIT && !bank_sel) begin
            rd_mux = limit_timing;
        end else begin
            hit = 1'b0;
        end
    end

    // Read data registered so every output comes from a flop
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 16'h0000;
            reg_hit <= 1'b0;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : 16'h0000;
            reg_hit <= (reg_rd || reg_wr) && hit;
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < 3; ch++) begin : g_ch
            logic [2:0] ph_now;
            assign ph_now = phase_bus[3*ch +: 3];

            channel_drive_select u_sel (
                .freewheel_side(freewheel_side[ch]),
                .phase(gate_drive_cfg_pkg::phase_t'(phase_bus[3*ch +: 3])),
                .turnon_code(act_charge[5*ch +: 5]),
                .turnoff_code(act_discharge[5*ch +: 5]),
                .freewheel_code(fw_drive[5*ch +: 5]),
                .predrain_code(predrain[5*ch +: 5]),
                .drive_code(code_next[5*ch +: 5]),
                .use_limit(use_limit_next[ch])
            );

            // Codes are held against the register as it stood at the loading edge
            AST_TURNON_CODE: assert property (@(posedge clk) disable iff (!rst_n)
                ph_now == 3'h2 && !freewheel_side[ch]
                |=> drive_code_bus[5*ch +: 5] == $past(act_charge[5*ch +: 5]))
                else $error("turn-on code not applied");

            AST_TURNOFF_CODE: assert property (@(posedge clk) disable iff (!rst_n)
                ph_now == 3'h5 && !freewheel_side[ch]
                |=> drive_code_bus[5*ch +: 5] == $past(act_discharge[5*ch +: 5]))
                else $error("turn-off code not applied");

            AST_FW_CODE: assert property (@(posedge clk) disable iff (!rst_n)
                (ph_now == 3'h2 || ph_now == 3'h5) && freewheel_side[ch]
                |=> drive_code_bus[5*ch +: 5] == $past(fw_drive[5*ch +: 5]))
                else $error("freewheel code not applied");

            AST_PREDRAIN_CODE: assert property (@(posedge clk) disable iff (!rst_n)
                ph_now == 3'h4
                |=> drive_code_bus[5*ch +: 5] == $past(predrain[5*ch +: 5]))
                else $error("predischarge code not applied");

            AST_PARKED_CODE: assert property (@(posedge clk) disable iff (!rst_n)
                ph_now == 3'h0 || ph_now == 3'h1 || ph_now == 3'h3
                |=> drive_code_bus[5*ch +: 5] == 5'h00)
                else $error("code driven outside its phase");

            AST_LIMIT_PHASES: assert property (@(posedge clk) disable iff (!rst_n)
                ph_now == 3'h1 || ph_now == 3'h3 || ph_now == 3'h4
                |=> limit_active[ch])
                else $error("pre-drive limit missing");

            AST_LIMIT_QUIET: assert property (@(posedge clk) disable iff (!rst_n)
                ph_now == 3'h0 || ph_now == 3'h2 || ph_now == 3'h5
                |=> !limit_active[ch])
                else $error("pre-drive limit outside its phases");
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            drive_code_bus <= 15'h0000;
            limit_active <= 3'h0;
        end else begin
            drive_code_bus <= code_next;
            limit_active <= use_limit_next;
        end
    end

    // Static settings fanned out to the analog side
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            predrive_limit_bus <= 6'h00;
            active_blanking_time_3 <= 3'h4;
            active_blanking_time_4 <= 3'h4;
            active_cross_conduction_time_4 <= 3'h4;
            sense_load_large <= 1'b0;
        end else begin
            predrive_limit_bus <= limit_timing[5:0];
            active_blanking_time_3 <= limit_timing[`BLANK3_LSB +: `TIME_W];
            active_blanking_time_4 <= limit_timing[`BLANK4_LSB +: `TIME_W];
            active_cross_conduction_time_4 <= limit_timing[`CCP4_LSB +: `TIME_W];
            // Either bank's copy at 0x0c can be last written; the active one rules
            sense_load_large <= act_discharge[`SENSE_LOAD_BIT];
        end
    end

    // Host accesses as the port samples them, named by bank and offset
    sequence s_write(logic sel, logic [4:0] ofs);
        reg_wr && bank_sel == sel && reg_addr == ofs;
    endsequence

    sequence s_read(logic sel, logic [4:0] ofs);
        reg_rd && bank_sel == sel && reg_addr == ofs;
    endsequence

    // Anything outside the five registers, bank 1 at 0x0d included
    sequence s_stray_access;
        (reg_rd || reg_wr) && reg_addr != `OFS_CHARGE && reg_addr != `OFS_DISCHARGE
            && !(reg_addr == `OFS_LIMIT && !bank_sel);
    endsequence

    // Sense select takes one edge into the register and one more to the pin
    sequence s_sense_write;
        s_write(1'b0, `OFS_DISCHARGE) ##1 1'b1;
    endsequence

    // From the second held edge on, so power-up values at the first cannot trip it
    AST_RESET_VALUES: assert property (@(posedge clk)
        !rst_n ##1 !rst_n |-> act_charge == `RST_ACT_CHARGE && fw_drive == `RST_FW_DRIVE
            && act_discharge == `RST_ACT_DISCHARGE && predrain == `RST_PREDRAIN
            && limit_timing == `RST_LIMIT_TIMING)
        else $error("register not at reset value");

    AST_RESET_OUTPUTS: assert property (@(posedge clk)
        !rst_n ##1 !rst_n |-> reg_rdata == 16'h0000 && !reg_hit && drive_code_bus == 15'h0000
            && limit_active == 3'h0 && active_blanking_time_4 == 3'h4
            && active_cross_conduction_time_4 == 3'h4 && active_blanking_time_3 == 3'h4)
        else $error("output not at reset level");

    AST_RESERVED_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
        !act_charge[15] && !fw_drive[15] && !limit_timing[15])
        else $error("reserved bit set");

    AST_ACT_WRITE_LANDS: assert property (@(posedge clk) disable iff (!rst_n)
        s_write(1'b0, `OFS_CHARGE)
        |=> act_charge == ($past(reg_wdata) & `MASK_CHARGE) && $stable(fw_drive))
        else $error("active charge write lost");

    AST_FW_WRITE_LANDS: assert property (@(posedge clk) disable iff (!rst_n)
        s_write(1'b1, `OFS_CHARGE)
        |=> fw_drive == ($past(reg_wdata) & `MASK_CHARGE) && $stable(act_charge))
        else $error("freewheel write lost");

    AST_FW_WRITE_ISOLATED: assert property (@(posedge clk) disable iff (!rst_n)
        s_write(1'b1, `OFS_CHARGE) |=> $stable(act_charge))
        else $error("active charge changed on bank 1 write");

    AST_DISCHARGE_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
        s_write(1'b0, `OFS_DISCHARGE)
        |=> act_discharge == $past(reg_wdata) && $stable(predrain))
        else $error("active discharge write misrouted");

    AST_PREDRAIN_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
        s_write(1'b1, `OFS_DISCHARGE)
        |=> predrain == $past(reg_wdata) && $stable(act_discharge))
        else $error("predischarge write misrouted");

    AST_LIMIT_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
        s_write(1'b0, `OFS_LIMIT)
        |=> limit_timing == ($past(reg_wdata) & `MASK_LIMIT))
        else $error("limit write lost");

    AST_LIMIT_BANK1_IGNORED: assert property (@(posedge clk) disable iff (!rst_n)
        s_write(1'b1, `OFS_LIMIT) |=> $stable(limit_timing))
        else $error("limit changed on bank 1 write");

    AST_QUIET_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
        !reg_wr |=> $stable(act_charge) && $stable(fw_drive) && $stable(act_discharge)
            && $stable(predrain) && $stable(limit_timing))
        else $error("register changed without a write");

    AST_CHARGE_READ: assert property (@(posedge clk) disable iff (!rst_n)
        s_read(1'b0, `OFS_CHARGE)
        |=> reg_rdata == $past(act_charge) && reg_hit)
        else $error("active charge read wrong");

    AST_FW_READ: assert property (@(posedge clk) disable iff (!rst_n)
        s_read(1'b1, `OFS_CHARGE)
        |=> reg_rdata == $past(fw_drive) && reg_hit)
        else $error("freewheel read wrong");

    AST_DISCHARGE_READ: assert property (@(posedge clk) disable iff (!rst_n)
        s_read(1'b0, `OFS_DISCHARGE)
        |=> reg_rdata == $past(act_discharge) && reg_hit)
        else $error("active discharge read wrong");

    AST_PREDRAIN_READ: assert property (@(posedge clk) disable iff (!rst_n)
        s_read(1'b1, `OFS_DISCHARGE)
        |=> reg_rdata == $past(predrain) && reg_hit)
        else $error("predischarge read wrong");

    AST_READ_BACK: assert property (@(posedge clk) disable iff (!rst_n)
        s_read(1'b0, `OFS_LIMIT)
        |=> reg_rdata == $past(limit_timing) && reg_hit)
        else $error("limit read back wrong");

    AST_STRAY_ACCESS: assert property (@(posedge clk) disable iff (!rst_n)
        s_stray_access |=> reg_rdata == 16'h0000 && !reg_hit)
        else $error("unmapped access answered");

    AST_MAPPED_WRITE_HIT: assert property (@(posedge clk) disable iff (!rst_n)
        s_write(1'b0, `OFS_LIMIT) |=> reg_hit)
        else $error("mapped write not acknowledged");

    AST_SENSE_LOAD: assert property (@(posedge clk) disable iff (!rst_n)
        s_sense_write |=> sense_load_large == $past(reg_wdata[15], 2))
        else $error("sense load select wrong");

    AST_LIMIT_OUT: assert property (@(posedge clk) disable iff (!rst_n)
        1'b1 |=> predrive_limit_bus == $past(limit_timing[5:0]))
        else $error("pre-drive limit output wrong");

    AST_TIMING_OUT: assert property (@(posedge clk) disable iff (!rst_n)
        1'b1 |=> active_blanking_time_4 == $past(limit_timing[14:12]))
        else $error("blanking time output wrong");

    AST_BLANK3_OUT: assert property (@(posedge clk) disable iff (!rst_n)
        1'b1 |=> active_blanking_time_3 == $past(limit_timing[8:6]))
        else $error("third blanking time output wrong");

    AST_CCP4_OUT: assert property (@(posedge clk) disable iff (!rst_n)
        1'b1 |=> active_cross_conduction_time_4 == $past(limit_timing[11:9]))
        else $error("cross-conduction time output wrong");
endmodule

// ### test/cfg_host_model.sv
`timescale 1ns/10ps
// Host side of the register port; only drives between rising edges
module cfg_host_model (
    // Clock
    input wire logic clk,
    // Register access
    output logic bank_sel,
    output logic [4:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_hit
);
    initial begin
        bank_sel = 1'b0;
        reg_addr = 5'h1f;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 16'h0000;
    end

    // One word per access, strobe held across exactly one rising edge
    task automatic access(input logic wr, input logic bank, input logic [4:0] addr,
        input logic [15:0] data, output logic [15:0] rdata, output logic hit);
        @(negedge clk);
        bank_sel = bank;
        reg_addr = addr;
        reg_wdata = data;
        reg_wr = wr;
        reg_rd = !wr;
        @(negedge clk);
        rdata = reg_rdata;
        hit = reg_hit;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        // Idle lines carry junk so a stale value cannot pass for a match
        reg_addr = ~addr;
        reg_wdata = ~data;
    endtask
endmodule

// ### test/test_gate_drive_current_cfg_bank.sv
`timescale 1ns/10ps
module test_gate_drive_current_cfg_bank;
    logic clk, rst_n, bank_sel, reg_wr, reg_rd, reg_hit, sense_load_large, rd_hit;
    logic [4:0] reg_addr, code;
    logic [15:0] reg_wdata, reg_rdata, rd_val;
    logic [2:0] freewheel_side, limit_active, blank3, blank4, ccp4;
    logic [8:0] phase_bus;
    logic [14:0] drive_code_bus;
    logic [5:0] predrive_limit_bus;
    int miscompares = 0;
    int cmp_count = 0;
    // Register table: bank, offset, reset value, readable mask, pattern
    logic bk [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    logic [4:0] ofs [5] = '{5'h0b, 5'h0b, 5'h0c, 5'h0c, 5'h0d};
    logic [15:0] rstv [5] = '{16'h18c6, 16'h18c6, 16'h1ce7, 16'h318c, 16'h4900};
    logic [15:0] msk [5] = '{16'h7fff, 16'h7fff, 16'hffff, 16'hffff, 16'h7fff};
    logic [15:0] pat [5] = '{16'h0443, 16'h1d09, 16'h10a6, 16'ha96c, 16'h14f9};

    gate_drive_current_cfg_bank DUT (.clk(clk), .rst_n(rst_n), .bank_sel(bank_sel),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_hit(reg_hit), .freewheel_side(freewheel_side),
        .phase_bus(phase_bus), .drive_code_bus(drive_code_bus), .limit_active(limit_active),
        .predrive_limit_bus(predrive_limit_bus), .active_blanking_time_3(blank3),
        .active_blanking_time_4(blank4), .active_cross_conduction_time_4(ccp4),
        .sense_load_large(sense_load_large));

    cfg_host_model HOST (.clk(clk), .bank_sel(bank_sel), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_hit(reg_hit));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rd(input logic bank, input logic [4:0] addr, input logic [15:0] exp,
        input logic hit);
        HOST.access(1'b0, bank, addr, 16'h0000, rd_val, rd_hit);
        check(rd_val, exp);
        check({15'h0000, rd_hit}, {15'h0000, hit});
    endtask

    task automatic wr(input int i, input logic [15:0] data);
        HOST.access(1'b1, bk[i], ofs[i], data, rd_val, rd_hit);
        check(rd_val, 16'h0000);
        check({15'h0000, rd_hit}, 16'h0001);
    endtask

    // Timing fields and limits laid out as bits 14:0 of the 0x0d register
    task automatic static_chk(input logic [15:0] exp, input logic sense);
        repeat (2) @(negedge clk);
        check({1'b0, blank4, ccp4, blank3, predrive_limit_bus}, exp & 16'h7fff);
        check({15'h0000, sense_load_large}, {15'h0000, sense});
    endtask

    task automatic final_report();
        $display("comparisons=%0d miscompares=%0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        final_report();
    end

    initial begin
        rst_n = 1'b0;
        freewheel_side = 3'h0;
        phase_bus = 9'h000;
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        for (int i = 0; i < 5; i++) rd(bk[i], ofs[i], rstv[i], 1'b1);
        static_chk(rstv[4], 1'b0);
        for (int i = 0; i < 5; i += 2) wr(i, 16'hffff);
        for (int i = 1; i < 5; i += 2) rd(bk[i], ofs[i], rstv[i], 1'b1);
        for (int i = 1; i < 5; i += 2) wr(i, 16'hffff);
        for (int i = 0; i < 5; i++) rd(bk[i], ofs[i], msk[i], 1'b1);
        static_chk(16'h7fff, 1'b1);
        for (int i = 0; i < 5; i++) wr(i, pat[i]);
        for (int i = 0; i < 5; i++) rd(bk[i], ofs[i], pat[i], 1'b1);
        static_chk(pat[4], 1'b0);
        HOST.access(1'b1, 1'b1, 5'h0d, 16'h0000, rd_val, rd_hit);
        check({15'h0000, rd_hit}, 16'h0000);
        rd(1'b1, 5'h0d, 16'h0000, 1'b0);
        rd(1'b0, 5'h0d, pat[4], 1'b1);
        rd(1'b0, 5'h0a, 16'h0000, 1'b0);
        for (int ph = 0; ph < 6; ph++) begin
            for (int s = 0; s < 2; s++) begin
                @(negedge clk);
                phase_bus = {3{ph[2:0]}};
                freewheel_side = {3{s[0]}};
                repeat (3) @(negedge clk);
                for (int c = 0; c < 3; c++) begin
                    code = 5'h00;
                    if (ph == 2) code = s ? pat[1][5*c+:5] : pat[0][5*c+:5];
                    if (ph == 5) code = s ? pat[1][5*c+:5] : pat[2][5*c+:5];
                    if (ph == 4) code = pat[3][5*c+:5];
                    if (ph != 4 || s == 0) check({11'h0, drive_code_bus[5*c+:5]}, {11'h0, code});
                    check({15'h0, limit_active[c]}, {15'h0, ph == 1 || ph == 3 || ph == 4});
                end
            end
        end
        final_report();
    end
endmodule
